/* sic_i2c_ctrl.sv */
// Notes on behaviour
// [RQ1] Start, restart, stop request bits make conditions; hardware clears them when done.
// [RQ2] Condition output select low suppresses start/stop on SCL and SDA.
// [RQ3] Ack output enable picks the ack value bit instead of data on SDA.
// [RQ4] SCL output stop enable releases the SCL output.
// [RQ5] SCL low hold enable keeps SCL low.
// [RQ6] Clock pin open-drain bit selects open-drain instead of push-pull drive.
// [RQ7] SDA delay code n delays SDA by n to n+1 count source cycles; the code gives n-1 to n cycles for n of 1 or more, and no delay for code 0.
// [RQ8] Software keeps the SDA delay at zero outside I2C mode.
// [RQ9] Clock sync enable lets another master holding SCL low stall the clock.
// [RQ10] SCL force low replaces the transfer clock on SCL with low.
// [RQ11] SDA output disable puts SDA in high impedance.
// [RQ12] I2C mode select switches the pins between I2C and plain serial use.
// [RQ13] Bus busy sets on a detected start and clears on a detected stop.
// [RQ14] Software writing 0 clears bus busy; writing 1 leaves it.
// [RQ15] Data pin select routes SDA to one of three pins or none.
// [RQ16] Receive pin select routes SCL to one of three pins or none.
// [RQ17] Software sets pin routing first and leaves it alone while running.
// [RQ18] Control fields are plain read/write bits except hardware-cleared ones.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module sic_i2c_ctrl #(
    parameter int ADDR_W = 12,
    parameter int NPIN = sic_pkg::NPINS
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Serial data path
    input wire logic baud_tick,
    input wire logic tx_data_bit,
    input wire logic tx_clock,
    output logic scl_sync_stall,
    output logic rx_scl_level,
    output logic rx_sda_level,
    // Data / SDA port pins
    input wire logic [NPIN-1:0] data_pin_in,
    output logic [NPIN-1:0] data_pin_out,
    output logic [NPIN-1:0] data_pin_oe_n,
    // Receive / SCL port pins
    input wire logic [NPIN-1:0] recv_pin_in,
    output logic [NPIN-1:0] recv_pin_out,
    output logic [NPIN-1:0] recv_pin_oe_n,
    // Serial clock pin
    output logic clk_pin_out,
    output logic clk_pin_oe_n
);
    import sic_pkg::*;

    logic [7:0] cond_ctrl;
    logic [7:0] phase_ctrl;
    logic [7:0] wait_ctrl;
    logic [7:0] mode_ctrl;
    logic [7:0] route_sel;
    logic bus_busy_flag;
    logic [IRQ_N-1:0] irq_stat;
    logic [IRQ_N-1:0] irq_mask;

    // Bus decode
    logic [IDX_W-1:0] idx;
    logic mapped;
    logic wr_en;
    logic rd_setup;
    logic [7:0] wbyte;
    logic [7:0] rd_val;
    assign idx = paddr[ADDR_LSB +: IDX_W];
    assign mapped = (idx == IDX_COND) || (idx == IDX_PHASE) || (idx == IDX_WAIT)
        || (idx == IDX_MODE) || (idx == IDX_ROUTE) || (idx == IDX_IRQ_STAT)
        || (idx == IDX_IRQ_MASK);
    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign wbyte = pwdata[7:0];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Field views
    logic start_cond_request;
    logic restart_cond_request;
    logic stop_cond_request;
    logic cond_output_select;
    logic ack_value_bit;
    logic ack_output_enable;
    logic scl_output_stop_enable;
    logic scl_low_hold_enable;
    logic clock_pin_open_drain;
    logic [DLY_W-1:0] sda_delay_code;
    logic clock_sync_enable;
    logic scl_wait_output;
    logic scl_force_low;
    logic sda_output_disable;
    logic i2c_mode_select;
    logic [2:0] data_pin_select;
    logic [1:0] recv_pin_select;
    assign start_cond_request = cond_ctrl[B_START_REQ];
    assign restart_cond_request = cond_ctrl[B_RESTART_REQ];
    assign stop_cond_request = cond_ctrl[B_STOP_REQ];
    assign cond_output_select = cond_ctrl[B_COND_SEL];
    assign ack_value_bit = cond_ctrl[B_ACK_VAL];
    assign ack_output_enable = cond_ctrl[B_ACK_OE];
    assign scl_output_stop_enable = cond_ctrl[B_SCL_STOP];
    assign scl_low_hold_enable = cond_ctrl[B_SCL_HOLD];
    assign clock_pin_open_drain = phase_ctrl[B_CLK_OD];
    assign sda_delay_code = phase_ctrl[B_DLY_HI:B_DLY_LO];
    assign clock_sync_enable = wait_ctrl[B_SYNC];
    assign scl_wait_output = wait_ctrl[B_WAIT_OUT];
    assign scl_force_low = wait_ctrl[B_FORCE_LOW];
    assign sda_output_disable = wait_ctrl[B_SDA_DIS];
    assign i2c_mode_select = mode_ctrl[B_I2C_MODE];
    assign data_pin_select = route_sel[B_DSEL_HI:B_DSEL_LO];
    assign recv_pin_select = route_sel[B_RSEL_HI:B_RSEL_LO];

    // Condition generator
    typedef enum logic [1:0] {
        SIC_CG_IDLE,
        SIC_CG_A,
        SIC_CG_B,
        SIC_CG_C
    } sic_cg_t;
    sic_cg_t cg_state;
    sic_kind_t cg_kind;
    logic cg_done;
    logic cond_scl;
    logic cond_sda;
    logic cg_busy;
    assign cg_busy = (cg_state != SIC_CG_IDLE);
    assign cg_done = (cg_state == SIC_CG_C) && baud_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cg_state <= SIC_CG_IDLE;
            cg_kind <= SIC_KIND_START;
        end else begin
            case (cg_state)
                SIC_CG_IDLE: begin
                    // Start beats restart beats stop when several are pending
                    if (i2c_mode_select && cond_output_select && baud_tick) begin //[RQ2]
                        if (start_cond_request) begin //[RQ1]
                            cg_kind <= SIC_KIND_START;
                            cg_state <= SIC_CG_A;
                        end else if (restart_cond_request) begin
                            cg_kind <= SIC_KIND_RESTART;
                            cg_state <= SIC_CG_A;
                        end else if (stop_cond_request) begin
                            cg_kind <= SIC_KIND_STOP;
                            cg_state <= SIC_CG_A;
                        end
                    end
                end
                SIC_CG_A: if (baud_tick) begin
                    cg_state <= SIC_CG_B;
                end
                SIC_CG_B: if (baud_tick) begin
                    cg_state <= SIC_CG_C;
                end
                SIC_CG_C: if (baud_tick) begin
                    cg_state <= SIC_CG_IDLE;
                end
                default: cg_state <= SIC_CG_IDLE;
            endcase
        end
    end

    always_comb begin
        cond_scl = 1'b1;
        cond_sda = 1'b1;
        if (cg_kind == SIC_KIND_STOP) begin
            cond_scl = (cg_state != SIC_CG_A);
            cond_sda = (cg_state == SIC_CG_C);
        end else begin
            cond_scl = (cg_state != SIC_CG_C);
            cond_sda = (cg_state == SIC_CG_A);
        end
    end

    // Register file
    logic [7:0] next_cond;
    always_comb begin
        next_cond = cond_ctrl;
        if (cg_done) begin
            next_cond[B_START_REQ + 32'(cg_kind)] = 1'b0; //[RQ1]
        end
        // A software write in the same cycle overrides the hardware clear
        if (wr_en && idx == IDX_COND) begin
            next_cond = wbyte; //[RQ18]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_ctrl <= RST_REG;
            phase_ctrl <= RST_REG;
            wait_ctrl <= RST_REG;
            mode_ctrl <= RST_REG;
            route_sel <= RST_REG;
            irq_mask <= '0;
        end else begin
            cond_ctrl <= next_cond;
            if (wr_en && idx == IDX_PHASE) begin
                phase_ctrl <= wbyte & PHASE_RW_MASK;
            end
            if (wr_en && idx == IDX_WAIT) begin
                wait_ctrl <= wbyte & WAIT_RW_MASK;
            end
            if (wr_en && idx == IDX_MODE) begin
                mode_ctrl <= wbyte & MODE_RW_MASK & ~(8'h0_1 << B_BUSY);
            end
            if (wr_en && idx == IDX_ROUTE) begin
                route_sel <= wbyte & ROUTE_RW_MASK;
            end
            if (wr_en && idx == IDX_IRQ_MASK) begin
                irq_mask <= wbyte[IRQ_N-1:0];
            end
        end
    end

    always_comb begin
        rd_val = 8'h0_0;
        case (idx)
            IDX_COND: rd_val = cond_ctrl;
            IDX_PHASE: rd_val = phase_ctrl;
            IDX_WAIT: rd_val = wait_ctrl;
            IDX_MODE: rd_val = mode_ctrl | ({7'h0_0, bus_busy_flag} << B_BUSY);
            IDX_ROUTE: rd_val = route_sel;
            IDX_IRQ_STAT: rd_val = {{(8-IRQ_N){1'b0}}, irq_stat};
            IDX_IRQ_MASK: rd_val = {{(8-IRQ_N){1'b0}}, irq_mask};
            default: rd_val = 8'h0_0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_setup) begin
            prdata <= {24'h00_0000, rd_val};
        end
    end

    // Pin input routing
    logic scl_in;
    logic sda_in;
    logic scl_prev;
    logic sda_prev;
    logic start_det;
    logic stop_det;
    always_comb begin
        sda_in = 1'b1;
        case (data_pin_select)
            DSEL_PIN0: sda_in = data_pin_in[0]; //[RQ15]
            DSEL_PIN1: sda_in = data_pin_in[1];
            DSEL_PIN2: sda_in = data_pin_in[2];
            default: sda_in = 1'b1;
        endcase
        scl_in = (recv_pin_select == 2'h0) ? 1'b1 : recv_pin_in[recv_pin_select - 2'h1]; //[RQ16]
    end
    assign rx_scl_level = scl_in;
    assign rx_sda_level = sda_in;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl_in;
            sda_prev <= sda_in;
        end
    end
    // Edges are only taken with SCL high on both samples to reject data changes
    assign start_det = i2c_mode_select && scl_in && scl_prev && sda_prev && !sda_in;
    assign stop_det = i2c_mode_select && scl_in && scl_prev && !sda_prev && sda_in;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_busy_flag <= 1'b0;
        end else if (start_det) begin
            bus_busy_flag <= 1'b1; //[RQ13]
        end else if (stop_det) begin
            bus_busy_flag <= 1'b0;
        end else if (wr_en && idx == IDX_MODE && !wbyte[B_BUSY]) begin
            bus_busy_flag <= 1'b0; //[RQ14]
        end
    end

    // Interrupt status: set beats write-one-to-clear
    logic [IRQ_N-1:0] irq_ev;
    assign irq_ev = {cg_done, stop_det, start_det};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= irq_ev
                | (irq_stat & ~((wr_en && idx == IDX_IRQ_STAT) ? wbyte[IRQ_N-1:0] : '0));
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // SDA source and digital delay on the count source
    logic sda_src;
    logic [DLY_DEPTH-1:0] dly_line;
    logic sda_del;
    assign sda_src = ack_output_enable ? ack_value_bit : tx_data_bit; //[RQ3]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_line <= '1;
        end else if (baud_tick) begin
            dly_line <= {dly_line[DLY_DEPTH-2:0], sda_src};
        end
    end
    // Phase of pclk against the tick gives the extra partial cycle
    assign sda_del = (sda_delay_code == '0) ? sda_src : dly_line[sda_delay_code - 3'h1]; //[RQ7]

    // Pin drive
    logic scl_val;
    logic scl_release;
    logic sda_val;
    logic sda_release;
    always_comb begin
        scl_val = tx_clock;
        scl_release = 1'b0;
        sda_val = sda_del;
        sda_release = 1'b0;
        if (i2c_mode_select) begin //[RQ12]
            if (cg_busy) begin
                scl_val = cond_scl; //[RQ2]
                sda_val = cond_sda;
            end else if (scl_force_low || scl_low_hold_enable || scl_wait_output) begin
                scl_val = 1'b0; //[RQ10] [RQ5]
            end else if (scl_output_stop_enable) begin
                scl_val = 1'b1; //[RQ4]
            end
            // Open drain: a high level is simply not driven
            scl_release = scl_val;
            sda_release = sda_val;
        end else begin
            scl_release = 1'b1;
        end
        if (sda_output_disable) begin
            sda_release = 1'b1; //[RQ11]
        end
    end
    assign scl_sync_stall = clock_sync_enable && i2c_mode_select && scl_release && !scl_in; //[RQ9]

    logic [NPIN-1:0] dsel_hit;
    logic [NPIN-1:0] rsel_hit;
    assign dsel_hit = {data_pin_select == DSEL_PIN2, data_pin_select == DSEL_PIN1,
        data_pin_select == DSEL_PIN0};
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            assign rsel_hit[gi] = (recv_pin_select == 2'(gi + 1));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    data_pin_out[gi] <= 1'b1;
                    data_pin_oe_n[gi] <= 1'b1;
                    recv_pin_out[gi] <= 1'b1;
                    recv_pin_oe_n[gi] <= 1'b1;
                end else begin
                    data_pin_out[gi] <= sda_val;
                    data_pin_oe_n[gi] <= !dsel_hit[gi] || sda_release; //[RQ15]
                    recv_pin_out[gi] <= scl_val;
                    recv_pin_oe_n[gi] <= !rsel_hit[gi] || scl_release; //[RQ16]
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_pin_out <= 1'b1;
            clk_pin_oe_n <= 1'b0;
        end else begin
            clk_pin_out <= tx_clock;
            clk_pin_oe_n <= clock_pin_open_drain && tx_clock; //[RQ6]
        end
    end

    // Checks
    AST_REQ_CLEARED: assert property (@(posedge pclk) disable iff (!presetn) //[RQ1]
        (cg_done && !(wr_en && idx == IDX_COND)) |=> !cond_ctrl[B_START_REQ + 32'(cg_kind)])
        else $error("request bit not cleared after condition");
    AST_NO_COND_WHEN_OFF: assert property (@(posedge pclk) disable iff (!presetn) //[RQ2]
        (!cg_busy && !cond_output_select) |=> !cg_busy)
        else $error("condition started while output select low");
    AST_ACK_ON_SDA: assert property (@(posedge pclk) disable iff (!presetn) //[RQ3]
        ack_output_enable |-> sda_src == ack_value_bit)
        else $error("SDA source is not the ack value");
    AST_SCL_RELEASED: assert property (@(posedge pclk) disable iff (!presetn) //[RQ4]
        (i2c_mode_select && !cg_busy && scl_output_stop_enable && !scl_force_low
        && !scl_low_hold_enable && !scl_wait_output) |-> scl_release)
        else $error("SCL still driven with output stop enabled");
    AST_SCL_HELD_LOW: assert property (@(posedge pclk) disable iff (!presetn) //[RQ5]
        (i2c_mode_select && !cg_busy && (scl_low_hold_enable || scl_force_low))
        |-> !scl_val && !scl_release)
        else $error("SCL not held low");
    AST_CLK_OD: assert property (@(posedge pclk) disable iff (!presetn) //[RQ6]
        (clock_pin_open_drain && tx_clock) |=> clk_pin_oe_n)
        else $error("clock pin driven high in open-drain mode");
    AST_DELAY_ONE: assert property (@(posedge pclk) disable iff (!presetn) //[RQ7]
        (sda_delay_code == 3'h1 && baud_tick) ##1 (sda_delay_code == 3'h1)
        |-> sda_del == $past(sda_src))
        else $error("SDA delay of one tick wrong");
    AST_SYNC_STALL: assert property (@(posedge pclk) disable iff (!presetn) //[RQ9]
        (!clock_sync_enable) |-> !scl_sync_stall)
        else $error("clock stall while sync disabled");
    AST_SDA_HIZ: assert property (@(posedge pclk) disable iff (!presetn) //[RQ11]
        sda_output_disable |=> &data_pin_oe_n)
        else $error("SDA driven while disabled");
    AST_BUSY_SET: assert property (@(posedge pclk) disable iff (!presetn) //[RQ13]
        start_det |=> bus_busy_flag)
        else $error("bus busy not set on start");
    AST_BUSY_KEEP: assert property (@(posedge pclk) disable iff (!presetn) //[RQ14]
        (bus_busy_flag && !stop_det && wr_en && idx == IDX_MODE && wbyte[B_BUSY])
        |=> bus_busy_flag)
        else $error("writing one changed bus busy");
    AST_ROUTE_NONE: assert property (@(posedge pclk) disable iff (!presetn) //[RQ15]
        (data_pin_select == 3'h0) |=> &data_pin_oe_n)
        else $error("data pin driven with no route");
    COV_START: cover property (@(posedge pclk) disable iff (!presetn)
        cg_done && cg_kind == SIC_KIND_START);
    COV_STOP: cover property (@(posedge pclk) disable iff (!presetn)
        cg_done && cg_kind == SIC_KIND_STOP);
    COV_BUSY: cover property (@(posedge pclk) disable iff (!presetn)
        start_det ##[1:200] stop_det);
    COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule

/* sic_pkg.sv */
package sic_pkg;
    // Register indices; byte address is four times the index
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_COND = 10'h0bc;
    localparam logic [IDX_W-1:0] IDX_PHASE = 10'h0bd;
    localparam logic [IDX_W-1:0] IDX_WAIT = 10'h0be;
    localparam logic [IDX_W-1:0] IDX_MODE = 10'h0bf;
    localparam logic [IDX_W-1:0] IDX_ROUTE = 10'h18a;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h0c0;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0c1;
    localparam int ADDR_LSB = 2;

    // Condition control fields
    localparam int B_START_REQ = 0;
    localparam int B_RESTART_REQ = 1;
    localparam int B_STOP_REQ = 2;
    localparam int B_COND_SEL = 3;
    localparam int B_ACK_VAL = 4;
    localparam int B_ACK_OE = 5;
    localparam int B_SCL_STOP = 6;
    localparam int B_SCL_HOLD = 7;
    // Clock phase / delay fields
    localparam int B_CLK_PHASE = 1;
    localparam int B_CLK_OD = 3;
    localparam int B_DLY_LO = 5;
    localparam int B_DLY_HI = 7;
    localparam logic [7:0] PHASE_RW_MASK = 8'he_a;
    // Wait / sync fields
    localparam int B_MODE2 = 0;
    localparam int B_SYNC = 1;
    localparam int B_WAIT_OUT = 2;
    localparam int B_INIT = 4;
    localparam int B_FORCE_LOW = 5;
    localparam int B_SDA_DIS = 6;
    localparam logic [7:0] WAIT_RW_MASK = 8'h7_f;
    // Mode / busy fields
    localparam int B_I2C_MODE = 0;
    localparam int B_BUSY = 2;
    localparam logic [7:0] MODE_RW_MASK = 8'h7_b;
    // Pin route fields
    localparam int B_DSEL_LO = 0;
    localparam int B_DSEL_HI = 2;
    localparam int B_RSEL_LO = 4;
    localparam int B_RSEL_HI = 5;
    localparam logic [7:0] ROUTE_RW_MASK = 8'h7_7;
    localparam logic [2:0] DSEL_PIN0 = 3'h1;
    localparam logic [2:0] DSEL_PIN1 = 3'h2;
    localparam logic [2:0] DSEL_PIN2 = 3'h5;
    // Interrupt status bits
    localparam int IRQ_N = 3;
    localparam int I_START_DET = 0;
    localparam int I_STOP_DET = 1;
    localparam int I_COND_DONE = 2;

    localparam logic [7:0] RST_REG = 8'h0_0;
    localparam int NPINS = 3;
    localparam int DLY_W = 3;
    localparam int DLY_DEPTH = 8;

    typedef enum logic [1:0] {
        SIC_KIND_START,
        SIC_KIND_RESTART,
        SIC_KIND_STOP
    } sic_kind_t;
endpackage

/* sic_bus_peer.sv */
`timescale 1ns/1ps
module sic_bus_peer (
    // Device pin drive
    input wire logic [2:0] data_pin_out,
    input wire logic [2:0] data_pin_oe_n,
    input wire logic [2:0] recv_pin_out,
    input wire logic [2:0] recv_pin_oe_n,
    // Other bus devices pulling lines low; a long scl_low stretches the clock
    input wire logic [2:0] sda_low,
    input wire logic [2:0] scl_low,
    // Wire levels seen by everyone
    output logic [2:0] data_pin_in,
    output logic [2:0] recv_pin_in
);
    // Pull-ups make a released line high, so no stale value survives a release
    assign data_pin_in = (data_pin_oe_n | data_pin_out) & ~sda_low;
    assign recv_pin_in = (recv_pin_oe_n | recv_pin_out) & ~scl_low;
endmodule

/* test_serial_i2c_mode_control.sv */
`timescale 1ns/1ps
module test_serial_i2c_mode_control;
    import sic_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, baud_tick = 0;
    logic tx_data_bit = 1, tx_clock = 1, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, irq, scl_sync_stall, rx_scl_level, rx_sda_level;
    logic clk_pin_out, clk_pin_oe_n;
    logic [2:0] data_pin_in, data_pin_out, data_pin_oe_n, recv_pin_in, recv_pin_out;
    logic [2:0] recv_pin_oe_n, sda_low = 3'h0, scl_low = 3'h0;
    logic [9:0] reg_ix [5] = '{IDX_COND, IDX_PHASE, IDX_WAIT, IDX_MODE, IDX_ROUTE};
    logic [7:0] wr_val [5] = '{8'hf8, 8'hff, 8'hff, 8'hff, 8'hf5};
    logic [7:0] rw_msk [5] = '{8'hff, PHASE_RW_MASK, WAIT_RW_MASK, MODE_RW_MASK, ROUTE_RW_MASK};
    logic [2:0] dcode [3] = '{DSEL_PIN0, DSEL_PIN1, DSEL_PIN2};
    int miscompares = 0, cmp_count = 0, cyc = 0;

    initial forever #50 pclk = ~pclk;

    sic_i2c_ctrl sic_i2c_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .baud_tick, .tx_data_bit, .tx_clock,
        .scl_sync_stall, .rx_scl_level, .rx_sda_level, .data_pin_in, .data_pin_out,
        .data_pin_oe_n, .recv_pin_in, .recv_pin_out, .recv_pin_oe_n, .clk_pin_out,
        .clk_pin_oe_n);
    sic_bus_peer sic_bus_peer_inst (.data_pin_out, .data_pin_oe_n, .recv_pin_out,
        .recv_pin_oe_n, .sda_low, .scl_low, .data_pin_in, .recv_pin_in);

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'h0};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] ix, input logic [7:0] d);
        apb(1'b1, ix, d);
    endtask

    task automatic rc(input string n, input logic [9:0] ix, input logic [7:0] e);
        apb(1'b0, ix, 8'h00);
        chk(n, {24'h00_0000, e}, rd);
    endtask

    // n count-source cycles, each followed by room for the registered pins to follow
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge pclk);
            baud_tick <= 1'b1;
            @(posedge pclk);
            baud_tick <= 1'b0;
            // Pins are registered: a check at the edge sees the previous edge's value
            repeat (2) @(posedge pclk);
        end
    endtask

    task automatic settle;
        repeat (4) @(posedge pclk);
    endtask

    task automatic t_regs;
        for (int i = 0; i < 5; i++) begin
            rc("reset value", reg_ix[i], 8'h00);
            wr(reg_ix[i], wr_val[i]);
            rc("read back", reg_ix[i], wr_val[i] & rw_msk[i]);
            wr(reg_ix[i], 8'h00);
        end
        wr(10'h001, 8'hff);
        chk("unmapped slverr", 32'(err), 1);
        rc("unmapped read", 10'h001, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_cond;
        wr(IDX_ROUTE, 8'h11);
        wr(IDX_MODE, 8'h01);
        wr(IDX_COND, 8'h01);
        tk(4);
        chk("no condition sda", 1, data_pin_in[0]);
        rc("request pending", IDX_COND, 8'h01);
        tx_clock <= 1'b0;
        tx_data_bit <= 1'b0;
        wr(IDX_MODE, 8'h01);
        wr(IDX_IRQ_MASK, 8'h04);
        for (int k = 0; k < 3; k++) begin
            wr(IDX_COND, 8'h08 | (8'h01 << k));
            tk(2);
            chk("condition sda", 0, data_pin_in[0]);
            chk("condition scl", 1, recv_pin_in[0]);
            tk(2);
            rc("request cleared", IDX_COND, 8'h08);
            rc("busy", IDX_MODE, (k < 2) ? 8'h05 : 8'h01);
        end
        rc("irq status", IDX_IRQ_STAT, 8'h07);
        chk("irq done", 1, irq);
        wr(IDX_IRQ_MASK, 8'h00);
        @(posedge pclk);
        chk("irq masked", 0, irq);
        wr(IDX_IRQ_MASK, 8'h04);
        @(posedge pclk);
        chk("irq unmasked", 1, irq);
        wr(IDX_IRQ_STAT, 8'h07);
        @(posedge pclk);
        chk("irq cleared", 0, irq);
        wr(IDX_COND, 8'h00);
        $display("test conditions done");
    endtask

    task automatic t_peer;
        tx_clock <= 1'b1;
        tx_data_bit <= 1'b1;
        settle;
        sda_low <= 3'h1;
        settle;
        chk("sda level", 0, rx_sda_level);
        rc("busy on start", IDX_MODE, 8'h05);
        sda_low <= 3'h0;
        settle;
        rc("busy on stop", IDX_MODE, 8'h01);
        sda_low <= 3'h1;
        settle;
        wr(IDX_MODE, 8'h05);
        rc("busy write one", IDX_MODE, 8'h05);
        wr(IDX_MODE, 8'h01);
        rc("busy write zero", IDX_MODE, 8'h01);
        sda_low <= 3'h0;
        $display("test far side busy done");
    endtask

    task automatic t_pins;
        tx_clock <= 1'b0;
        wr(IDX_COND, 8'h40);
        settle;
        chk("scl stopped", 1, recv_pin_in[0]);
        tx_clock <= 1'b1;
        wr(IDX_COND, 8'h80);
        settle;
        chk("scl held", 0, recv_pin_in[0]);
        wr(IDX_COND, 8'h00);
        wr(IDX_WAIT, 8'h20);
        settle;
        chk("scl forced", 0, recv_pin_in[0]);
        wr(IDX_WAIT, 8'h00);
        settle;
        chk("scl clock", 1, recv_pin_in[0]);
        wr(IDX_COND, 8'h20);
        settle;
        chk("ack sda", 0, data_pin_in[0]);
        wr(IDX_COND, 8'h30);
        tx_data_bit <= 1'b0;
        settle;
        chk("nack sda", 1, data_pin_in[0]);
        wr(IDX_COND, 8'h00);
        settle;
        chk("data sda", 0, data_pin_in[0]);
        wr(IDX_WAIT, 8'h40);
        settle;
        chk("sda disabled", 1, data_pin_oe_n[0]);
        wr(IDX_WAIT, 8'h02);
        scl_low <= 3'h1;
        settle;
        chk("sync stall", 1, scl_sync_stall);
        wr(IDX_WAIT, 8'h00);
        settle;
        chk("sync off", 0, scl_sync_stall);
        scl_low <= 3'h0;
        wr(IDX_PHASE, 8'h08);
        settle;
        chk("clock open drain", 1, clk_pin_oe_n);
        chk("clock pin level", 1, clk_pin_out);
        wr(IDX_PHASE, 8'h00);
        settle;
        chk("clock push pull", 0, clk_pin_oe_n);
        $display("test pin controls done");
    endtask

    task automatic t_delay;
        wr(IDX_PHASE, 8'h60);
        tx_data_bit <= 1'b1;
        tk(4);
        tx_data_bit <= 1'b0;
        tk(2);
        chk("sda delayed", 1, data_pin_in[0]);
        tk(2);
        chk("sda after delay", 0, data_pin_in[0]);
        wr(IDX_PHASE, 8'h20);
        tx_data_bit <= 1'b1;
        settle;
        chk("sda one tick before", 0, data_pin_in[0]);
        tk(1);
        chk("sda one tick after", 1, data_pin_in[0]);
        wr(IDX_PHASE, 8'h00);
        $display("test sda delay done");
    endtask

    task automatic t_route;
        wr(IDX_MODE, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr(IDX_ROUTE, {2'h0, 2'(k + 1), 1'b0, dcode[k]});
            tx_data_bit <= 1'b1;
            scl_low <= 3'h1 << k;
            settle;
            chk("data routed", 3'(~(3'h1 << k)), data_pin_oe_n);
            chk("scl routed low", 0, rx_scl_level);
            scl_low <= ~(3'h1 << k);
            settle;
            chk("scl routed high", 1, rx_scl_level);
        end
        wr(IDX_ROUTE, 8'h00);
        settle;
        chk("data unrouted", 3'h7, data_pin_oe_n);
        chk("scl unrouted", 1, rx_scl_level);
        scl_low <= 3'h0;
        $display("test routing done");
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            final_report;
        end
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_cond;
        t_peer;
        t_pins;
        t_delay;
        t_route;
        final_report;
    end
endmodule
